/* include/icw_pkg.sv */
/*
  Constants, field layout and carriers for the two-wire bus controller control word.
  Assumes an APB slave on pclk and a separate bus-controller clock for the link side.
*/
package icw_pkg;
  localparam logic [11:0] ADDR_CONTROL_WORD = 12'h000;
  localparam logic [11:0] ADDR_STATUS_WORD  = 12'h014;
  localparam logic [11:0] ADDR_LINE_STATE   = 12'h040;
  localparam logic [31:0] CONTROL_RESET     = 32'h0000_0000;
  localparam int BIT_PE   = 0;
  localparam int BIT_SM_L = 4;
  localparam int BIT_SM_H = 5;
  localparam int BIT_GC   = 6;
  localparam int BIT_FTX  = 7;
  localparam int BIT_FRX  = 8;
  localparam int BIT_DTX  = 9;
  localparam int BIT_DRX  = 10;
  localparam int BIT_FL_L = 13;
  localparam int BIT_FL_H = 14;
  localparam int BIT_FS   = 15;
  localparam logic [31:0] CONTROL_RW_MASK   = 32'h0000_e7f1;
  localparam logic [1:0]  SPEED_STANDARD    = 2'h0;
  localparam logic [1:0]  SPEED_FAST        = 2'h1;
  localparam logic [7:0]  GC_STATUS_CODE    = 8'h01;
  localparam logic [7:0]  GENERAL_CALL_ADDR = 8'h00;
  localparam logic [7:0]  HW_GC_SECOND      = 8'h01;
  localparam logic [2:0]  FILT_1 = 3'h1;
  localparam logic [2:0]  FILT_2 = 3'h2;
  localparam logic [2:0]  FILT_4 = 3'h4;

  typedef enum logic [1:0] {
    ICW_STOP_IDLE = 2'b00,
    ICW_STOP_LOW  = 2'b01,
    ICW_STOP_SCLH = 2'b11,
    ICW_STOP_SDAH = 2'b10
  } icw_stop_e;

  typedef struct packed {
    logic       enable;
    logic [1:0] speed;
    logic       gc_direct;
    logic [1:0] filter;
    logic       stop_req;
  } icw_cfg_s;

  typedef struct packed {
    logic       valid;
    logic       hw_call;
    logic [7:0] data;
  } icw_gc_s;
endpackage : icw_pkg

/* rtl/icw_control.sv */
/*
  Control word of the two-wire bus controller: APB register, flushes across clock
  domains, DMA enables, pin spike filters, forced STOP and general-call routing.
  Assumes pclk at 100 MHz, link clock free running, open-drain pads outside.
*/
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module icw_control (
  // apb
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // dma
  input  wire logic         dma_tx_eot,
  input  wire logic         dma_rx_eot,
  output logic              dma_tx_active,
  output logic              dma_rx_active,
  // link clock side
  input  wire logic         link_clk,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              scl_out,
  output logic              scl_oe,
  output logic              sda_out,
  output logic              sda_oe,
  // receive path from the slave core (link clock)
  input  icw_pkg::icw_gc_s  gc_in,
  // towards the transmit and receive cores
  output icw_pkg::icw_cfg_s cfg_link,
  output logic              tx_path_rst,
  output logic              rx_path_rst,
  output logic              scl_filt,
  output logic              sda_filt,
  output logic              rxq_valid,
  output logic       [7:0]  rxq_data
);
  import icw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // apb register
  logic [31:0] ctrl_q;
  logic [7:0]  status_q;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        txf_done;
  logic        rxf_done;
  logic        gc_stat_ev;
  logic [1:0]  line_sync;

  assign pready  = 1'b1;
  assign wr_ctrl = psel && penable && pwrite && (paddr == ADDR_CONTROL_WORD);
  assign wr_stat = psel && penable && pwrite && (paddr == ADDR_STATUS_WORD);

  always_comb begin
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    if (paddr == ADDR_CONTROL_WORD) begin
      prdata = ctrl_q;
    end else if (paddr == ADDR_STATUS_WORD) begin
      prdata = {24'h00_0000, status_q};
    end else if (paddr == ADDR_LINE_STATE) begin
      prdata = {30'h0000_0000, line_sync};
    end else begin
      pslverr = psel && penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CONTROL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata & CONTROL_RW_MASK;
        // a flush already running stays set until finished
        if (ctrl_q[BIT_FTX]) ctrl_q[BIT_FTX] <= 1'b1;
        if (ctrl_q[BIT_FRX]) ctrl_q[BIT_FRX] <= 1'b1;
      end
      if (txf_done) ctrl_q[BIT_FTX] <= 1'b0;
      if (rxf_done) ctrl_q[BIT_FRX] <= 1'b0;
      // end of transfer clears the enable unless software sets it now
      if (dma_tx_eot && !(wr_ctrl && pwdata[BIT_DTX])) ctrl_q[BIT_DTX] <= 1'b0;
      if (dma_rx_eot && !(wr_ctrl && pwdata[BIT_DRX])) ctrl_q[BIT_DRX] <= 1'b0;
      if (!ctrl_q[BIT_PE]) begin
        ctrl_q[BIT_FS] <= wr_ctrl ? pwdata[BIT_FS] : 1'b0;
      end
    end
  end

  assign dma_tx_active = ctrl_q[BIT_PE] && ctrl_q[BIT_DTX];
  assign dma_rx_active = ctrl_q[BIT_PE] && ctrl_q[BIT_DRX];

  ////////////////////////////////////////////////////////////////////////////
  // flush handshakes: request level to link domain, acknowledge back
  logic [2:0] txreq_l;
  logic [2:0] rxreq_l;
  logic [1:0] txack_p;
  logic [1:0] rxack_p;
  logic       lrst_n;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      txreq_l <= 3'h0;
      rxreq_l <= 3'h0;
    end else begin
      txreq_l <= {txreq_l[1:0], ctrl_q[BIT_FTX]};
      rxreq_l <= {rxreq_l[1:0], ctrl_q[BIT_FRX]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txack_p <= 2'h0;
      rxack_p <= 2'h0;
    end else begin
      txack_p <= {txack_p[0], txreq_l[2]};
      rxack_p <= {rxack_p[0], rxreq_l[2]};
    end
  end

  assign txf_done = ctrl_q[BIT_FTX] && txack_p[1];
  assign rxf_done = ctrl_q[BIT_FRX] && rxack_p[1];
  // link-domain path resets held while the flush request is seen there
  assign lrst_n      = txreq_l[1] || rxreq_l[1];
  assign tx_path_rst = txreq_l[1] || !cfg_link.enable;
  assign rx_path_rst = rxreq_l[1] || !cfg_link.enable;

  ////////////////////////////////////////////////////////////////////////////
  // configuration to link domain, two stages (quasi-static fields)
  icw_cfg_s cfg_m;
  icw_cfg_s cfg_src;

  always_comb begin
    cfg_src.enable    = ctrl_q[BIT_PE];
    cfg_src.speed     = ctrl_q[BIT_SM_H:BIT_SM_L];
    cfg_src.gc_direct = ctrl_q[BIT_GC];
    cfg_src.filter    = ctrl_q[BIT_FL_H:BIT_FL_L];
    cfg_src.stop_req  = ctrl_q[BIT_FS];
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      cfg_m    <= '0;
      cfg_link <= '0;
    end else begin
      cfg_m    <= cfg_src;
      cfg_link <= cfg_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and spike filters (link domain)
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [2:0] scl_cnt;
  logic [2:0] sda_cnt;
  logic [2:0] filt_len;

  // extra agreeing samples past the first: a level held one clock longer than the
  // spike width passes; the synchroniser alone already drops one-clock pulses
  always_comb begin
    case (cfg_link.filter)
      2'h1:    filt_len = FILT_1 - 3'h1;
      2'h2:    filt_len = FILT_2 - 3'h1;
      2'h3:    filt_len = FILT_4 - 3'h1;
      default: filt_len = 3'h0;
    endcase
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      scl_s    <= 3'h7;
      sda_s    <= 3'h7;
      scl_cnt  <= 3'h0;
      sda_cnt  <= 3'h0;
      scl_filt <= 1'b1;
      sda_filt <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      // a new level must persist longer than the spike width
      if (scl_s[1] != scl_s[2] || scl_s[2] == scl_filt) begin
        scl_cnt <= 3'h0;
      end else if (scl_cnt >= filt_len) begin
        scl_filt <= scl_s[2];
        scl_cnt  <= 3'h0;
      end else begin
        scl_cnt <= scl_cnt + 3'h1;
      end
      if (sda_s[1] != sda_s[2] || sda_s[2] == sda_filt) begin
        sda_cnt <= 3'h0;
      end else if (sda_cnt >= filt_len) begin
        sda_filt <= sda_s[2];
        sda_cnt  <= 3'h0;
      end else begin
        sda_cnt <= sda_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_sync <= 2'h3;
    end else begin
      line_sync <= {scl_filt, sda_filt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forced STOP: SCL and SDA low, release SCL, then release SDA
  icw_stop_e stop_q;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= ICW_STOP_IDLE;
    end else if (!cfg_link.enable || lrst_n) begin
      stop_q <= ICW_STOP_IDLE;
    end else begin
      case (stop_q)
        ICW_STOP_IDLE: if (cfg_link.stop_req) stop_q <= ICW_STOP_LOW;
        ICW_STOP_LOW:  stop_q <= ICW_STOP_SCLH;
        ICW_STOP_SCLH: if (scl_filt) stop_q <= ICW_STOP_SDAH;
        ICW_STOP_SDAH: if (!cfg_link.stop_req) stop_q <= ICW_STOP_IDLE;
        default:       stop_q <= ICW_STOP_IDLE;
      endcase
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = (stop_q == ICW_STOP_LOW);
  assign sda_oe  = (stop_q == ICW_STOP_LOW) || (stop_q == ICW_STOP_SCLH);

  ////////////////////////////////////////////////////////////////////////////
  // general call routing (link domain) and status code hand-over
  logic gc_to_status;
  logic gc_tog_q;
  logic [2:0] gc_tog_s;

  assign gc_to_status = gc_in.valid && cfg_link.gc_direct && !gc_in.hw_call;

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      rxq_valid <= 1'b0;
      rxq_data  <= 8'h00;
      gc_tog_q  <= 1'b0;
    end else begin
      // transparent: message goes to the receive queue untouched
      rxq_valid <= gc_in.valid && !gc_to_status && !rx_path_rst;
      rxq_data  <= gc_in.data;
      if (gc_to_status) gc_tog_q <= ~gc_tog_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc_tog_s <= 3'h0;
    end else begin
      gc_tog_s <= {gc_tog_s[1:0], gc_tog_q};
    end
  end

  assign gc_stat_ev = gc_tog_s[2] ^ gc_tog_s[1];

  // status code set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 8'h00;
    end else if (gc_stat_ev) begin
      status_q <= GC_STATUS_CODE;
    end else if (wr_stat || !ctrl_q[BIT_PE]) begin
      status_q <= 8'h00;
    end
  end
endmodule : icw_control

/* test/icw_chk_asserts.sv */
/* Port checker for icw_control.
   Bound to every icw_control instance; sees its ports only. */
`timescale 1ns/10ps
module icw_chk (
  // apb
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  // dma
  input wire logic          dma_tx_eot,
  input wire logic          dma_rx_eot,
  input wire logic          dma_tx_active,
  input wire logic          dma_rx_active,
  // link side
  input wire logic          link_clk,
  input wire logic          scl_out,
  input wire logic          scl_oe,
  input wire logic          sda_out,
  input wire logic          sda_oe,
  input icw_pkg::icw_gc_s   gc_in,
  input icw_pkg::icw_cfg_s  cfg_link,
  input wire logic          tx_path_rst,
  input wire logic          rx_path_rst,
  input wire logic          rxq_valid,
  input wire logic [7:0]    rxq_data
);
  import icw_pkg::*;
  logic cw;
  assign cw = psel && penable && pwrite && paddr == ADDR_CONTROL_WORD;
  AST_DMA_TX: assert property (@(posedge pclk) disable iff (!presetn)
    dma_tx_eot && !cw |=> !dma_tx_active) else $error("dma tx on after eot");
  AST_DMA_RX: assert property (@(posedge pclk) disable iff (!presetn)
    dma_rx_eot && !cw |=> !dma_rx_active) else $error("dma rx on after eot");
  AST_PE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    cw && !pwdata[BIT_PE] |=> !dma_tx_active && !dma_rx_active) else $error("dma on while off");
  AST_TXF: assert property (@(posedge pclk) disable iff (!presetn)
    cw && pwdata[BIT_PE] && pwdata[BIT_FTX] |-> ##[1:40] tx_path_rst) else $error("no tx flush");
  AST_RXF: assert property (@(posedge pclk) disable iff (!presetn)
    cw && pwdata[BIT_PE] && pwdata[BIT_FRX] |-> ##[1:40] rx_path_rst) else $error("no rx flush");
  AST_GC_T: assert property (@(posedge link_clk) disable iff (!presetn)
    gc_in.valid && !gc_in.hw_call && !cfg_link.gc_direct && !rx_path_rst
    |=> rxq_valid && rxq_data == $past(gc_in.data)) else $error("call not forwarded");
  AST_GC_D: assert property (@(posedge link_clk) disable iff (!presetn)
    gc_in.valid && !gc_in.hw_call && cfg_link.gc_direct |=> !rxq_valid) else $error("call fwd");
  AST_GC_HW: assert property (@(posedge link_clk) disable iff (!presetn)
    gc_in.valid && gc_in.hw_call && !rx_path_rst |=> rxq_valid) else $error("hw call lost");
  AST_STOP: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(cfg_link.stop_req) |-> ##[1:6] (scl_oe && sda_oe)) else $error("no stop start");
  AST_OD: assert property (@(posedge link_clk) disable iff (!presetn)
    !scl_out && !sda_out) else $error("pad driven high");
endmodule : icw_chk

bind icw_control icw_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .dma_tx_eot(dma_tx_eot), .dma_rx_eot(dma_rx_eot),
  .dma_tx_active(dma_tx_active), .dma_rx_active(dma_rx_active), .link_clk(link_clk),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .gc_in(gc_in),
  .cfg_link(cfg_link), .tx_path_rst(tx_path_rst), .rx_path_rst(rx_path_rst),
  .rxq_valid(rxq_valid), .rxq_data(rxq_data));

/* test/icw_bus_peer.sv */
/* Far side of the two-wire bus: an open-drain peer.
   Both lines have pull-ups; the peer clock idles high between frames. */
`timescale 1ns/10ps
module icw_bus_peer (
  // device pads
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in,
  // peer pulls
  input  wire logic peer_scl_low,
  input  wire logic peer_sda_low
);
  // wired-and of both parties with a pull-up
  assign scl_in = !(scl_oe || peer_scl_low);
  assign sda_in = !(sda_oe || peer_sda_low);
endmodule : icw_bus_peer

/* test/i2c_control_word_upper_fields_tb_top.sv */
/* Self-checking bench for icw_control.
   Uses the checker bind and icw_bus_peer on the pads. */
`timescale 1ns/10ps
module i2c_control_word_upper_fields_tb_top;
  import icw_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, link_clk = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, dma_tx_eot = 0, dma_rx_eot = 0, dma_tx_active, dma_rx_active;
  logic scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, peer_scl = 0, peer_sda = 0;
  logic tx_path_rst, rx_path_rst, scl_filt, sda_filt, rxq_valid, saw_low = 0;
  logic [7:0] rxq_data;
  icw_gc_s gc_in = '0;
  icw_cfg_s cfg_link;
  int miscompares = 0, num_checks = 0, rxq_n = 0;
  int w [4] = '{2, 1, 2, 4};
  always #5 pclk = ~pclk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    if (rxq_valid) rxq_n++;
    if (!sda_filt) saw_low = 1;
  end
  icw_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_tx_eot(dma_tx_eot), .dma_rx_eot(dma_rx_eot),
    .dma_tx_active(dma_tx_active), .dma_rx_active(dma_rx_active), .link_clk(link_clk),
    .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .gc_in(gc_in), .cfg_link(cfg_link),
    .tx_path_rst(tx_path_rst), .rx_path_rst(rx_path_rst), .scl_filt(scl_filt),
    .sda_filt(sda_filt), .rxq_valid(rxq_valid), .rxq_data(rxq_data));
  icw_bus_peer peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in),
    .peer_scl_low(peer_scl), .peer_sda_low(peer_sda));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic poll(input int b);
    apb(1'b0, ADDR_CONTROL_WORD, '0);
    chk(r[b], 1'b1);
    for (int n = 0; n < 200 && r[b] !== 1'b0; n++) apb(1'b0, ADDR_CONTROL_WORD, '0);
  endtask : poll
  task automatic dma(input int b);
    logic [1:0] sel;
    sel = (b == BIT_DTX) ? 2'b01 : 2'b10;
    apb(1'b1, ADDR_CONTROL_WORD, 32'h1 | (32'h1 << b));
    chk({dma_rx_active, dma_tx_active}, sel);
    {dma_rx_eot, dma_tx_eot} <= sel;
    @(posedge pclk);
    {dma_rx_eot, dma_tx_eot} <= 2'b00;
    apb(1'b0, ADDR_CONTROL_WORD, '0);
    chk(r, 32'h1);
  endtask : dma
  task automatic gcall(input logic hw, input logic [7:0] d);
    repeat (40) @(posedge pclk);
    @(posedge link_clk);
    gc_in <= '{valid: 1'b1, hw_call: hw, data: d};
    @(posedge link_clk);
    gc_in <= '0;
    repeat (40) @(posedge pclk);
  endtask : gcall
  task automatic pull(input int n);
    saw_low = 0;
    @(posedge link_clk);
    peer_sda <= 1'b1;
    repeat (n) @(posedge link_clk);
    peer_sda <= 1'b0;
    repeat (14) @(posedge link_clk);
    @(posedge pclk);
  endtask : pull
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CONTROL_WORD, '0);
    chk(r, CONTROL_RESET);
    apb(1'b0, 12'h0fc, '0);
    chk({r[30:0], err}, 32'h1);
    apb(1'b1, ADDR_CONTROL_WORD, 32'hffff_1801);
    apb(1'b0, ADDR_CONTROL_WORD, '0);
    chk(r, 32'h1);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ADDR_CONTROL_WORD, 32'h1 | 32'(s << BIT_SM_L));
      repeat (40) @(posedge pclk);
      chk(cfg_link.speed, s ? SPEED_FAST : SPEED_STANDARD);
    end
    apb(1'b1, ADDR_CONTROL_WORD, 32'h0000_6051);
    apb(1'b1, ADDR_CONTROL_WORD, 32'h0000_60d1);
    poll(BIT_FTX);
    chk(r, 32'h0000_6051);
    apb(1'b1, ADDR_CONTROL_WORD, 32'h0000_6151);
    poll(BIT_FRX);
    chk(r, 32'h0000_6051);
    dma(BIT_DTX);
    dma(BIT_DRX);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, ADDR_CONTROL_WORD, 32'h1 | 32'(f << BIT_FL_L));
      pull(w[f]);
      chk(saw_low, f == 0);
      pull(w[f] + 1);
      chk({saw_low, sda_filt}, 2'b11);
    end
    apb(1'b1, ADDR_CONTROL_WORD, 32'h0000_8001);
    for (int i = 0; i < 400 && sda_oe !== 1'b1; i++) @(posedge pclk);
    chk(sda_oe, 1'b1);
    for (int i = 0; i < 400 && (sda_oe | scl_oe) !== 1'b0; i++) @(posedge pclk);
    chk({scl_oe, sda_oe, scl_in, sda_in}, 4'b0011);
    apb(1'b1, ADDR_CONTROL_WORD, 32'h1);
    gcall(1'b0, GENERAL_CALL_ADDR);
    chk(rxq_n, 1);
    apb(1'b1, ADDR_CONTROL_WORD, 32'h41);
    gcall(1'b0, GENERAL_CALL_ADDR);
    apb(1'b0, ADDR_STATUS_WORD, '0);
    chk({r[23:0], rxq_n[7:0]}, {16'h0, GC_STATUS_CODE, 8'h1});
    apb(1'b1, ADDR_STATUS_WORD, '0);
    gcall(1'b1, HW_GC_SECOND);
    apb(1'b0, ADDR_STATUS_WORD, '0);
    chk({r[23:0], rxq_n[7:0]}, 32'h2);
    apb(1'b1, ADDR_CONTROL_WORD, 32'h0000_0201);
    apb(1'b1, ADDR_CONTROL_WORD, 32'h0000_0200);
    repeat (40) @(posedge pclk);
    chk({dma_tx_active, tx_path_rst, rx_path_rst}, 3'b011);
    apb(1'b0, ADDR_CONTROL_WORD, '0);
    chk(r, 32'h0000_0200);
    finish_test();
  end
endmodule : i2c_control_word_upper_fields_tb_top
